// ---- verilog/upper_map_pkg.sv ----
// Shared constants and types for the upper memory map decoder.
// Assumes a 32-bit address space and a 32-bit classic Wishbone register port.
package upper_map_pkg;

    // Register word offsets, byte addressed.
    localparam logic [7:0] REG_LOW_MEM_TOP    = 8'h00;
    localparam logic [7:0] REG_SMM_CTRL       = 8'h04;
    localparam logic [7:0] REG_APERTURE_BASE  = 8'h08;
    localparam logic [7:0] REG_APERTURE_SIZE  = 8'h0C;
    localparam logic [7:0] REG_GFX_MEM_BASE   = 8'h10;
    localparam logic [7:0] REG_GFX_MEM_LIMIT  = 8'h14;
    localparam logic [7:0] REG_GFX_PREF_BASE  = 8'h18;
    localparam logic [7:0] REG_GFX_PREF_LIMIT = 8'h1C;
    localparam logic [7:0] REG_XLATE_TABLE    = 8'h20;
    localparam logic [7:0] REG_STATUS         = 8'h24;

    // Field positions inside the SMM control and status registers.
    localparam int SMM_GLOBAL_BIT = 0;
    localparam int SMM_OPEN_BIT   = 1;
    localparam int SMM_CLOSE_BIT  = 2;
    localparam int SMM_SEG_BIT    = 3;
    localparam int SMM_HIGH_BIT   = 4;
    localparam int SMM_SIZE_LSB   = 5;
    localparam int SMM_CTRL_W     = 7;
    localparam int STAT_SRC_LSB   = 3;
    localparam int STAT_CNT_LSB   = 16;

    // Reset values and the aperture size limit.
    localparam logic [31:0] LOW_MEM_TOP_RST = 32'h1000_0000;
    localparam logic [31:0] WINDOW_BASE_RST = 32'hFFF0_0000;
    localparam logic [31:0] WINDOW_LIM_RST  = 32'h0000_0000;
    localparam logic [2:0]  AP_SIZE_256MB   = 3'h6;
    localparam logic [2:0]  AP_SIZE_MAX     = 3'h6;

    // Fixed ranges and sizes.
    localparam logic [31:0] SEG_MIN_BYTES      = 32'h0002_0000;
    localparam logic [31:0] APERTURE_MIN_BYTES = 32'h0040_0000;
    localparam logic [31:0] INTC0_LO           = 32'hFEC0_0000;
    localparam logic [31:0] INTC0_HI           = 32'hFEC7_FFFF;
    localparam logic [31:0] INTMSG_LO          = 32'hFEE0_0000;
    localparam logic [31:0] INTMSG_HI          = 32'hFEEF_FFFF;
    localparam logic [31:0] HIGH_SMM_LO        = 32'hFEDA_0000;
    localparam logic [31:0] HIGH_SMM_HI        = 32'hFEDB_FFFF;
    localparam logic [31:0] HIGH_SMM_OFS_MASK  = 32'h0001_FFFF;
    localparam logic [31:0] COMPAT_SMM_BASE    = 32'h000A_0000;
    localparam logic [31:0] ZERO_ADDR          = 32'h0000_0000;
    localparam int          PAGE_SHIFT         = 12;
    localparam int          ENTRY_SHIFT        = 2;

    // Request sources and routing targets.
    typedef enum logic [1:0] {SRC_CPU, SRC_HUB, SRC_GFX} source_t;
    typedef enum logic [2:0] {TGT_DRAM, TGT_HUB, TGT_GFX, TGT_INTMSG, TGT_TERM, TGT_NONE} target_t;

endpackage

// ---- verilog/upper_map_decoder.sv ----
// Upper memory map decoder: routes each request to DRAM, hub, graphics port,
// interrupt message or termination, or marks it invalid. Registers sit on a classic Wishbone slave.
// Assumes requests and bus signals are synchronous to clk_i.
`timescale 1ns/100ps

module upper_map_decoder
    import upper_map_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Request to be decoded.
    input  wire logic        req_valid_i,
    input  wire logic [31:0] req_addr_i,
    input  wire source_t     req_src_i,
    input  wire logic        req_write_i,
    input  wire logic        req_smm_i,
    input  wire logic        req_code_i,
    // Registered routing decision.
    output logic             rt_valid_o,
    output target_t          rt_target_o,
    output logic      [31:0] rt_addr_o,
    output logic             rt_write_o,
    output logic             rt_translate_o,
    output logic      [31:0] rt_table_addr_o,
    output logic             rt_drop_write_o,
    output logic             rt_zero_read_o,
    output logic             host_target_ready_n_o
);

    // The comparators are written for a 32-bit map only.
    if (ADDR_W != 32) begin : g_width_check
        $error("upper_map_decoder supports only ADDR_W = 32");
    end

    logic [31:0]           low_memory_top, next_low_memory_top;
    logic [SMM_CTRL_W-1:0] extended_smram_ctrl, next_extended_smram_ctrl;
    logic [31:0]           aperture_base, next_aperture_base;
    logic [2:0]            aperture_size_sel, next_aperture_size_sel;
    logic [31:0]           gfx_mem_window_base, next_gfx_mem_window_base;
    logic [31:0]           gfx_mem_window_limit, next_gfx_mem_window_limit;
    logic [31:0]           gfx_prefetch_window_base, next_gfx_prefetch_window_base;
    logic [31:0]           gfx_prefetch_window_limit, next_gfx_prefetch_window_limit;
    logic [31:0]           xlate_table_base, next_xlate_table_base;
    logic [15:0]           term_count, next_term_count;
    logic [31:0]           next_wb_dat;
    logic                  next_wb_ack;
    logic [31:0]           rd_word;
    logic                  wr_hit;

    // Byte-lane merge of a write into an old register value.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Range decode of the current request.
    logic [31:0] seg_size, seg_lo, ap_size, ap_mask, ap_base_eff, ap_offset;
    logic        global_smm_enable, smm_open, top_smm_segment_en, high_smm_enable;
    logic        seg_active, high_active, smm_ok, foreign;
    logic        in_seg, in_high, in_intc, in_intmsg, in_ap, in_mem_win, in_pref_win;

    // Configuration-derived limits and address comparisons.
    always_comb begin
        global_smm_enable  = extended_smram_ctrl[SMM_GLOBAL_BIT];
        smm_open           = extended_smram_ctrl[SMM_OPEN_BIT];
        top_smm_segment_en = extended_smram_ctrl[SMM_SEG_BIT];
        high_smm_enable    = extended_smram_ctrl[SMM_HIGH_BIT];
        seg_size    = SEG_MIN_BYTES << extended_smram_ctrl[SMM_SIZE_LSB +: 2];
        seg_lo      = low_memory_top - seg_size;
        seg_active  = global_smm_enable && top_smm_segment_en;
        high_active = global_smm_enable && high_smm_enable;
        smm_ok      = smm_open || (req_smm_i && req_code_i);
        foreign     = (req_src_i != SRC_CPU);
        ap_size     = APERTURE_MIN_BYTES << aperture_size_sel;
        ap_mask     = ~(ap_size - 32'h0000_0001);
        ap_base_eff = aperture_base & ap_mask;
        ap_offset   = req_addr_i - ap_base_eff;
        in_seg      = (req_addr_i >= seg_lo) && (req_addr_i < low_memory_top);
        in_high     = (req_addr_i >= HIGH_SMM_LO) && (req_addr_i <= HIGH_SMM_HI);
        in_intc     = (req_addr_i >= INTC0_LO) && (req_addr_i <= INTC0_HI);
        in_intmsg   = (req_addr_i >= INTMSG_LO) && (req_addr_i <= INTMSG_HI);
        in_ap       = ((req_addr_i & ap_mask) == ap_base_eff);
        in_mem_win  = (req_addr_i >= gfx_mem_window_base)
                   && (req_addr_i <= gfx_mem_window_limit);
        in_pref_win = (req_addr_i >= gfx_prefetch_window_base)
                   && (req_addr_i <= gfx_prefetch_window_limit);
    end

    // Decision state.
    logic    next_rt_valid, next_rt_write, next_rt_translate, next_drop, next_zero;
    target_t next_rt_target;
    logic [31:0] next_rt_addr, next_table_addr;
    source_t last_src, next_last_src;

    // Priority decode: SMM, fixed ranges, low memory, aperture, windows, subtractive.
    always_comb begin
        next_rt_valid     = req_valid_i;
        next_rt_write     = req_write_i;
        next_rt_addr      = req_addr_i;
        next_rt_translate = 1'b0;
        next_table_addr   = ZERO_ADDR;
        next_drop         = 1'b0;
        next_zero         = 1'b0;
        next_last_src     = req_valid_i ? req_src_i : last_src;
        next_rt_target    = TGT_HUB;
        if (foreign && ((in_seg && seg_active) || (in_high && high_active))) begin
            // Foreign masters are kept out of SMM space.
            next_rt_target = TGT_DRAM;
            next_rt_addr   = ZERO_ADDR;
            next_drop      = req_write_i;
        end else if (in_seg && seg_active) begin
            if (smm_ok && req_smm_i) begin
                next_rt_target = TGT_DRAM;
            end else if (smm_open && !req_smm_i) begin
                next_rt_target = TGT_DRAM;
            end else begin
                next_rt_target = TGT_TERM;
            end
        end else if (in_high && high_active && req_smm_i && smm_ok) begin
            next_rt_target = TGT_DRAM;
            next_rt_addr   = COMPAT_SMM_BASE | (req_addr_i & HIGH_SMM_OFS_MASK);
        end else if (in_intc && !foreign) begin
            next_rt_target = TGT_HUB;
        end else if (in_intmsg && foreign && req_write_i) begin
            next_rt_target = TGT_INTMSG;
        end else if (req_addr_i < low_memory_top) begin
            next_rt_target = TGT_DRAM;
        end else if (in_ap) begin
            next_rt_target    = TGT_DRAM;
            next_rt_translate = 1'b1;
            next_table_addr   = xlate_table_base
                              + ((ap_offset >> PAGE_SHIFT) << ENTRY_SHIFT);
        end else if (in_mem_win || in_pref_win) begin
            next_rt_target = TGT_GFX;
        end else begin
            next_rt_target = TGT_HUB;
        end
        // A master cannot be routed back onto its own interface, and the
        // graphics port may only reach memory or interrupt messages; such space is invalid.
        if ((req_src_i == SRC_GFX && (next_rt_target == TGT_HUB || next_rt_target == TGT_GFX))
            || (req_src_i == SRC_HUB && next_rt_target == TGT_HUB)
            || (foreign && in_intmsg && !req_write_i)) begin
            next_rt_target    = TGT_NONE;
            next_rt_translate = 1'b0;
            next_drop         = req_write_i;
            next_zero         = !req_write_i;
        end
    end

    // Decision registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rt_valid_o      <= 1'b0;
            rt_target_o     <= TGT_NONE;
            rt_addr_o       <= ZERO_ADDR;
            rt_write_o      <= 1'b0;
            rt_translate_o  <= 1'b0;
            rt_table_addr_o <= ZERO_ADDR;
            rt_drop_write_o <= 1'b0;
            rt_zero_read_o  <= 1'b0;
            last_src        <= SRC_CPU;
        end else begin
            rt_valid_o      <= next_rt_valid;
            rt_target_o     <= next_rt_target;
            rt_addr_o       <= next_rt_addr;
            rt_write_o      <= next_rt_write;
            rt_translate_o  <= next_rt_translate;
            rt_table_addr_o <= next_table_addr;
            rt_drop_write_o <= next_drop;
            rt_zero_read_o  <= next_zero;
            last_src        <= next_last_src;
        end
    end

    // The message is completed locally, so target ready follows the decision.
    assign host_target_ready_n_o = !(rt_valid_o && rt_target_o == TGT_INTMSG);

    // Register readback mux; aperture base low bits read as zero.
    always_comb begin
        case (wb_adr_i)
            REG_LOW_MEM_TOP:    rd_word = low_memory_top;
            REG_SMM_CTRL:       rd_word = {25'h0000000, extended_smram_ctrl};
            REG_APERTURE_BASE:  rd_word = ap_base_eff;
            REG_APERTURE_SIZE:  rd_word = {29'h00000000, aperture_size_sel};
            REG_GFX_MEM_BASE:   rd_word = gfx_mem_window_base;
            REG_GFX_MEM_LIMIT:  rd_word = gfx_mem_window_limit;
            REG_GFX_PREF_BASE:  rd_word = gfx_prefetch_window_base;
            REG_GFX_PREF_LIMIT: rd_word = gfx_prefetch_window_limit;
            REG_XLATE_TABLE:    rd_word = xlate_table_base;
            REG_STATUS:         rd_word = {term_count, 11'h000, last_src, rt_target_o};
            default:            rd_word = 32'h0000_0000;
        endcase
    end

    // Bus and register next values; a write lands on the edge that sees ack.
    always_comb begin
        wr_hit      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
        next_wb_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_wb_dat = next_wb_ack ? rd_word : 32'h0000_0000;
        next_low_memory_top            = low_memory_top;
        next_extended_smram_ctrl       = extended_smram_ctrl;
        next_aperture_base             = aperture_base;
        next_aperture_size_sel         = aperture_size_sel;
        next_gfx_mem_window_base       = gfx_mem_window_base;
        next_gfx_mem_window_limit      = gfx_mem_window_limit;
        next_gfx_prefetch_window_base  = gfx_prefetch_window_base;
        next_gfx_prefetch_window_limit = gfx_prefetch_window_limit;
        next_xlate_table_base          = xlate_table_base;
        next_term_count = term_count + 16'((rt_valid_o && rt_target_o == TGT_TERM) ? 1 : 0);
        if (wr_hit) begin
            case (wb_adr_i)
                REG_LOW_MEM_TOP:    next_low_memory_top =
                                        merge(low_memory_top, wb_dat_i, wb_sel_i);
                REG_SMM_CTRL:       next_extended_smram_ctrl = SMM_CTRL_W'(merge(
                                        {25'h0000000, extended_smram_ctrl}, wb_dat_i, wb_sel_i));
                REG_APERTURE_BASE:  next_aperture_base =
                                        merge(aperture_base, wb_dat_i, wb_sel_i) & ap_mask;
                REG_APERTURE_SIZE: begin
                    if (wb_sel_i[0] && wb_dat_i[2:0] <= AP_SIZE_MAX) begin
                        next_aperture_size_sel = wb_dat_i[2:0];
                    end
                end
                REG_GFX_MEM_BASE:   next_gfx_mem_window_base =
                                        merge(gfx_mem_window_base, wb_dat_i, wb_sel_i);
                REG_GFX_MEM_LIMIT:  next_gfx_mem_window_limit =
                                        merge(gfx_mem_window_limit, wb_dat_i, wb_sel_i);
                REG_GFX_PREF_BASE:  next_gfx_prefetch_window_base =
                                        merge(gfx_prefetch_window_base, wb_dat_i, wb_sel_i);
                REG_GFX_PREF_LIMIT: next_gfx_prefetch_window_limit =
                                        merge(gfx_prefetch_window_limit, wb_dat_i, wb_sel_i);
                REG_XLATE_TABLE:    next_xlate_table_base =
                                        merge(xlate_table_base, wb_dat_i, wb_sel_i);
                default: begin
                end
            endcase
        end
    end

    // Register file and bus answer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o                  <= 1'b0;
            wb_dat_o                  <= 32'h0000_0000;
            low_memory_top            <= LOW_MEM_TOP_RST;
            extended_smram_ctrl       <= '0;
            aperture_base             <= 32'h0000_0000;
            aperture_size_sel         <= AP_SIZE_256MB;
            gfx_mem_window_base       <= WINDOW_BASE_RST;
            gfx_mem_window_limit      <= WINDOW_LIM_RST;
            gfx_prefetch_window_base  <= WINDOW_BASE_RST;
            gfx_prefetch_window_limit <= WINDOW_LIM_RST;
            xlate_table_base          <= 32'h0000_0000;
            term_count                <= 16'h0000;
        end else begin
            wb_ack_o                  <= next_wb_ack;
            wb_dat_o                  <= next_wb_dat;
            low_memory_top            <= next_low_memory_top;
            extended_smram_ctrl       <= next_extended_smram_ctrl;
            aperture_base             <= next_aperture_base;
            aperture_size_sel         <= next_aperture_size_sel;
            gfx_mem_window_base       <= next_gfx_mem_window_base;
            gfx_mem_window_limit      <= next_gfx_mem_window_limit;
            gfx_prefetch_window_base  <= next_gfx_prefetch_window_base;
            gfx_prefetch_window_limit <= next_gfx_prefetch_window_limit;
            xlate_table_base          <= next_xlate_table_base;
            term_count                <= next_term_count;
        end
    end

    // Checks on the routing decision and registers; the |=> checks sample one cycle after the request.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_LATENCY: assert property (req_valid_i |=> rt_valid_o)
        else $error("decision not registered one cycle after request");
    AST_INTC: assert property (req_valid_i && !foreign && in_intc && !in_seg
        |=> rt_target_o == TGT_HUB)
        else $error("cpu interrupt controller access not sent to hub");
    AST_INTMSG: assert property (req_valid_i && foreign && req_write_i && in_intmsg
        |=> rt_target_o == TGT_INTMSG && !host_target_ready_n_o)
        else $error("foreign message write not turned into message");
    AST_HOST_TARGET_READY_N: assert property (!host_target_ready_n_o |-> rt_target_o == TGT_INTMSG)
        else $error("target ready without a message");
    AST_SMM_FOREIGN: assert property (req_valid_i && foreign && in_seg && seg_active
        |=> rt_addr_o == ZERO_ADDR && rt_drop_write_o == $past(req_write_i))
        else $error("foreign master reached SMM space");
    AST_SEG_TERM: assert property (req_valid_i && !foreign && in_seg && seg_active
        && !req_smm_i && !smm_open |=> rt_target_o == TGT_TERM)
        else $error("non-SMM segment access not terminated");
    AST_HIGH_REMAP: assert property (req_valid_i && !foreign && in_high && high_active
        && req_smm_i && req_code_i && !in_seg
        |=> rt_addr_o == (COMPAT_SMM_BASE | ($past(req_addr_i) & HIGH_SMM_OFS_MASK)))
        else $error("high SMM access not remapped");
    AST_AP_SIZE_RST: assert property ($past(rst_i) |-> aperture_size_sel == AP_SIZE_256MB)
        else $error("aperture size not 256 MB after reset");
    AST_AP_ALIGN: assert property (wb_ack_o && $past(wb_adr_i) == REG_APERTURE_BASE
        |-> (wb_dat_o & ~ap_mask) == 32'h0000_0000)
        else $error("aperture base low bits not zero");
    AST_INVALID: assert property (req_valid_i && foreign && !req_write_i && in_intmsg
        |=> rt_target_o == TGT_NONE && rt_zero_read_o && !rt_drop_write_o)
        else $error("invalid read not answered with zeros");

    COV_TERM: cover property (rt_valid_o && rt_target_o == TGT_TERM);
    COV_MSG: cover property (rt_valid_o && rt_target_o == TGT_INTMSG);
    COV_XLATE: cover property (rt_valid_o && rt_translate_o);
    COV_GFX: cover property (rt_valid_o && rt_target_o == TGT_GFX);

endmodule

// ---- tb/sysbus_msg_sink.sv ----
// Model of the system bus end that receives interrupt messages.
// Assumes decisions and target-ready arrive synchronous to clk_i.
`timescale 1ns/100ps
module sysbus_msg_sink
    import upper_map_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Decision seen on the system bus side.
    input  wire logic       rt_valid_i,
    input  wire target_t    rt_target_i,
    input  wire logic       host_target_ready_n_i,
    // Messages completed so far.
    output logic      [7:0] msg_count_o
);
    // A message only counts when the decoder signals target-ready with it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_count_o <= 8'h00;
        end else if (rt_valid_i && rt_target_i == TGT_INTMSG && !host_target_ready_n_i) begin
            msg_count_o <= msg_count_o + 8'h01;
        end
    end
endmodule

// ---- tb/upper_map_decoder_tb.sv ----
// Self-checking bench for the upper memory map decoder.
// Assumes the decoder answers one cycle after a request and acks Wishbone later.
`timescale 1ns/100ps
module upper_map_decoder_tb
    import upper_map_pkg::*;
;
    typedef struct {source_t s; logic [31:0] a; logic w, m, c; target_t t; logic [31:0] ea;} row_t;
    logic clk_i, rst_i, cyc, stb, we, rq_v, rq_w, rq_m, rq_c;
    logic [7:0] adr, msgs;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, rq_a, rta, tba;
    logic ack, rtv, tr, hrn, drw, zr, rw;
    source_t rq_s;
    target_t rtt;
    row_t rows[12];
    int err_total, n_compared, ticks;
    upper_map_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .req_valid_i(rq_v), .req_addr_i(rq_a), .req_src_i(rq_s),
        .req_write_i(rq_w), .req_smm_i(rq_m), .req_code_i(rq_c), .rt_valid_o(rtv),
        .rt_target_o(rtt), .rt_addr_o(rta), .rt_write_o(rw), .rt_translate_o(tr),
        .rt_table_addr_o(tba), .rt_drop_write_o(drw), .rt_zero_read_o(zr),
        .host_target_ready_n_o(hrn));
    sysbus_msg_sink sink (.clk_i(clk_i), .rst_i(rst_i), .rt_valid_i(rtv), .rt_target_i(rtt),
        .host_target_ready_n_i(hrn), .msg_count_o(msgs));
    // Free-running clock.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic report_and_stop();
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: a hung handshake must not stall the run forever.
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Classic single Wishbone access; request held until ack is sampled.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    // One request cycle, then an idle one while the decision is checked.
    task automatic req(input row_t r);
        @(posedge clk_i);
        rq_v <= 1'b1; rq_s <= r.s; rq_a <= r.a; rq_w <= r.w; rq_m <= r.m; rq_c <= r.c;
        @(posedge clk_i);
        rq_v <= 1'b0;
        #1;
        chk("valid", 32'h1, rtv);
        chk("target", r.t, rtt);
        if (r.ea !== 32'hFFFF_FFFF) chk("addr", r.ea, rta);
        chk("ready_n", (r.t == TGT_INTMSG) ? 32'h0 : 32'h1, hrn);
        chk("write", r.w, rw);
        chk("drop", r.w && (r.t == TGT_NONE || (r.s != SRC_CPU && r.ea == 32'h0)), drw);
        chk("zero", !r.w && r.t == TGT_NONE, zr);
    endtask
    initial begin
        {cyc, stb, we, adr, wdat, rq_v, rq_a, rq_w, rq_m, rq_c, err_total, n_compared, ticks} = '0;
        sel = 4'hF; rq_s = SRC_CPU; rst_i = 1'b1;
        rows = '{
            '{SRC_CPU, 32'h0FFE_0000, 0, 1, 1, TGT_DRAM, 32'h0FFE_0000},
            '{SRC_CPU, 32'h0FFF_FFFC, 0, 0, 0, TGT_TERM, 32'hFFFF_FFFF},
            '{SRC_CPU, 32'h0FFD_FFFF, 0, 0, 0, TGT_DRAM, 32'h0FFD_FFFF},
            '{SRC_GFX, 32'h0FFE_0040, 0, 0, 0, TGT_DRAM, 32'h0000_0000},
            '{SRC_HUB, 32'h0FFF_0000, 1, 0, 0, TGT_DRAM, 32'h0000_0000},
            '{SRC_CPU, 32'hFEC7_FFFF, 0, 0, 0, TGT_HUB, 32'hFEC7_FFFF},
            '{SRC_HUB, 32'hFEE0_0010, 1, 0, 0, TGT_INTMSG, 32'hFEE0_0010},
            '{SRC_CPU, 32'hFEDB_0004, 0, 1, 1, TGT_DRAM, 32'h000B_0004},
            '{SRC_CPU, 32'hD00F_FFFF, 0, 0, 0, TGT_GFX, 32'hD00F_FFFF},
            '{SRC_CPU, 32'hD010_0000, 0, 0, 0, TGT_HUB, 32'hD010_0000},
            '{SRC_HUB, 32'hFEE0_0000, 0, 0, 0, TGT_NONE, 32'hFFFF_FFFF},
            '{SRC_CPU, 32'hE000_3000, 0, 0, 0, TGT_DRAM, 32'hFFFF_FFFF}};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, REG_APERTURE_SIZE, 32'h0);
        chk("aperture_size_sel", 32'h6, q);
        wb(1'b1, REG_APERTURE_BASE, 32'hE123_4567);
        wb(1'b0, REG_APERTURE_BASE, 32'h0);
        chk("aperture_base", 32'hE000_0000, q);
        wb(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b1, REG_SMM_CTRL, 32'h19);
        wb(1'b1, REG_GFX_MEM_BASE, 32'hD000_0000);
        wb(1'b1, REG_GFX_MEM_LIMIT, 32'hD00F_FFFF);
        foreach (rows[i]) req(rows[i]);
        chk("translate", 32'h1, tr);
        chk("table", 32'hC, tba);
        chk("messages", 32'h1, msgs);
        wb(1'b1, REG_SMM_CTRL, 32'h01);
        req('{SRC_CPU, 32'h0FFE_0000, 0, 0, 0, TGT_DRAM, 32'h0FFE_0000});
        req('{SRC_CPU, 32'hFEDA_0000, 0, 1, 1, TGT_HUB, 32'hFEDA_0000});
        // Open segment lets a plain access through; largest size moves the segment floor.
        wb(1'b1, REG_SMM_CTRL, 32'h0B);
        req('{SRC_CPU, 32'h0FFF_0000, 0, 0, 0, TGT_DRAM, 32'h0FFF_0000});
        wb(1'b1, REG_SMM_CTRL, 32'h69);
        req('{SRC_CPU, 32'h0FF0_0000, 0, 0, 0, TGT_TERM, 32'hFFFF_FFFF});
        // Prefetchable window decodes like the plain one.
        wb(1'b1, REG_GFX_PREF_BASE, 32'hD800_0000);
        wb(1'b1, REG_GFX_PREF_LIMIT, 32'hD80F_FFFF);
        req('{SRC_CPU, 32'hD800_0000, 0, 0, 0, TGT_GFX, 32'hD800_0000});
        // An out-of-range size is refused; the smallest one shrinks the aperture.
        wb(1'b1, REG_APERTURE_SIZE, 32'h7);
        wb(1'b0, REG_APERTURE_SIZE, 32'h0);
        chk("aperture_size_sel_refused", 32'h6, q);
        wb(1'b1, REG_APERTURE_SIZE, 32'h0);
        req('{SRC_CPU, 32'hE040_0000, 0, 0, 0, TGT_HUB, 32'hE040_0000});
        // Mid-run reset must clear the decision and restore the aperture size.
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk("rst_valid", 32'h0, rtv);
        chk("rst_target", TGT_NONE, rtt);
        chk("rst_ready_n", 32'h1, hrn);
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, REG_APERTURE_SIZE, 32'h0);
        chk("aperture_size_sel_rst", 32'h6, q);
        report_and_stop();
    end
endmodule
